// ==== rtl/scr_pkg.sv ====
// Package of constants and types for the stage controller register block.
package scr_pkg;

  // ----------------------------------------------------------------------
  // Instances and bus decoding
  // ----------------------------------------------------------------------
  localparam int STAGES = 3;
  localparam logic [1:0] LAST_STAGE = 2'h2;
  localparam int STAGE_MSB = 7;
  localparam int STAGE_LSB = 6;
  localparam int IDX_MSB = 5;
  localparam int IDX_LSB = 2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Register word indexes within one stage window
  // ----------------------------------------------------------------------
  localparam logic [3:0] R_SOC = 4'h0;
  localparam logic [3:0] R_CNF = 4'h1;
  localparam logic [3:0] R_SAH = 4'h2;
  localparam logic [3:0] R_SAL = 4'h3;
  localparam logic [3:0] R_RAH = 4'h4;
  localparam logic [3:0] R_RAL = 4'h5;
  localparam logic [3:0] R_SBH = 4'h6;
  localparam logic [3:0] R_SBL = 4'h7;
  localparam logic [3:0] R_RBH = 4'h8;
  localparam logic [3:0] R_RBL = 4'h9;
  localparam logic [3:0] R_POM = 4'hA;
  localparam logic [3:0] R_STAT = 4'hB;

  // ----------------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------------
  localparam int SOC_OUT4_SOURCE_SEL = 7;
  localparam int SOC_OUT3_SOURCE_SEL = 6;
  localparam int SOC_SYNC_HI = 5;
  localparam int SOC_SYNC_LO = 4;
  localparam int SOC_OEN_D = 3;
  localparam int SOC_OEN_B = 2;
  localparam int SOC_OEN_C = 1;
  localparam int SOC_OEN_A = 0;
  localparam int CNF_HALF = 7;
  localparam int CNF_ALOCK = 6;
  localparam int CNF_LOCK = 5;
  localparam int CNF_MODE_HI = 4;
  localparam int CNF_MODE_LO = 3;
  localparam int CNF_POL = 2;
  localparam int CNF_CLK = 1;
  localparam int CNF_POME = 0;
  localparam int POM_B_LSB = 4;
  localparam logic [7:0] SOC_MASK_PLAIN = 8'h35;
  localparam logic [7:0] CNF_MASK_PLAIN = 8'hFE;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] CMP_RESET = 12'h000;
  localparam logic [15:0] RB_RESET = 16'h0000;
  localparam logic [1:0] SYNC_LEAD_A = 2'h0;
  localparam logic [1:0] SYNC_TRAIL_A = 2'h1;
  localparam logic [1:0] SYNC_LEAD_B = 2'h2;
  localparam logic [1:0] SYNC_TRAIL_B = 2'h3;

  typedef enum logic [1:0] {
    MODE_ONE_RAMP = 2'b00,
    MODE_TWO_RAMP = 2'b01,
    MODE_FOUR_RAMP = 2'b10,
    MODE_CENTER = 2'b11
  } scr_run_mode_e;

  // Signals from one waveform generator and its input blocks.
  typedef struct packed {
    logic [11:0] counter;
    logic count_down;
    logic [1:0] ramp_idx;
    logic wave_a;
    logic wave_b;
    logic fault_a;
    logic fault_b;
    logic capture_evt;
    logic sync_err;
  } scr_stage_in_s;

  // Pins, trigger, interrupts and settings of one stage.
  typedef struct packed {
    logic [3:0] pin_val;
    logic [3:0] pin_oe;
    logic [3:0] match;
    logic adc_sync;
    logic input_event_irq;
    logic end_cycle_irq;
    logic clk_fast;
    logic half_duty;
    scr_run_mode_e mode;
  } scr_stage_out_s;

endpackage

// ==== rtl/scr_stage_ctrl_regs.sv ====
// Register layer and output control of the three stage controllers.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

module scr_stage_ctrl_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire scr_pkg::scr_stage_in_s st_in [scr_pkg::STAGES],
  output scr_pkg::scr_stage_out_s st_out [scr_pkg::STAGES]
);
  import scr_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Drives a generator level onto a pin in the selected active level.
  function automatic logic lvl(input logic pol, input logic x);
    lvl = pol ? x : ~x;
  endfunction

  // Chooses the ADC trigger from the compare matches of one stage.
  function automatic logic sync_pick(input scr_run_mode_e mode,
                                     input logic [1:0] sel,
                                     input logic [3:0] m,
                                     input logic fa,
                                     input logic fb,
                                     input logic down);
    logic r;
    r = 1'b0;
    if (mode == MODE_CENTER) begin
      if (sel == SYNC_LEAD_A) begin
        r = m[1] & down;
      end else if (sel == SYNC_TRAIL_A) begin
        r = m[1] & ~down;
      end
    end else begin
      unique case (sel)
        SYNC_LEAD_A: r = m[0];
        SYNC_TRAIL_A: r = m[1] | fa;
        SYNC_LEAD_B: r = m[2];
        SYNC_TRAIL_B: r = m[3] | fb;
      endcase
    end
    sync_pick = r;
  endfunction

  // Compares one compare value with the generator counter.
  function automatic logic hit(input logic [11:0] cnt,
                               input logic [11:0] v);
    hit = (cnt == v);
  endfunction

  // Selects the read word of one stage from its register index.
  function automatic logic [31:0] rd_pick(input logic [3:0] idx,
                                          input logic last,
                                          input logic [7:0] soc,
                                          input logic [7:0] cfg,
                                          input logic [7:0] pom,
                                          input logic [2:0] stat);
    logic [31:0] r;
    r = RD_ZERO;
    unique case (idx)
      R_SOC: r = {24'h0, soc};
      R_CNF: r = {24'h0, cfg};
      R_POM: r = last ? {24'h0, pom} : RD_ZERO;
      R_STAT: r = {29'h0, stat};
      default: r = RD_ZERO;
    endcase
    rd_pick = r;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic dph_wr;
  logic dph_rd;
  logic [1:0] dph_stage;
  logic [3:0] dph_idx;
  logic [7:0] hi_latch;
  logic [31:0] rd_word [STAGES];

  wire addr_go = hsel & hready & htrans[1] & (hsize == SIZE_WORD);
  wire wr_go = dph_wr;
  wire [7:0] wbyte = hwdata[7:0];
  wire wr_hi = wr_go & ((dph_idx == R_SAH) | (dph_idx == R_RAH) |
                        (dph_idx == R_SBH) | (dph_idx == R_RBH));
  wire rd_hit = dph_rd & (dph_stage <= LAST_STAGE);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_hit ? rd_word[dph_stage] : RD_ZERO;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr <= 1'b0;
      dph_rd <= 1'b0;
      dph_stage <= 2'h0;
      dph_idx <= 4'h0;
    end else begin
      dph_wr <= addr_go & hwrite;
      dph_rd <= addr_go & ~hwrite;
      dph_stage <= haddr[STAGE_MSB:STAGE_LSB];
      dph_idx <= haddr[IDX_MSB:IDX_LSB];
    end
  end

  // A single high-byte latch serves every stage and every compare.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_latch <= BYTE_RESET;
    end else if (wr_hi) begin
      hi_latch <= wbyte;
    end
  end

  // ----------------------------------------------------------------------
  // Output matrix, last stage only
  // ----------------------------------------------------------------------
  logic [7:0] pom_buf;
  logic [7:0] pom_act;
  logic [STAGES-1:0] xfer;

  wire pom_wr = wr_go & (dph_stage == LAST_STAGE) & (dph_idx == R_POM);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pom_buf <= BYTE_RESET;
      pom_act <= BYTE_RESET;
    end else begin
      if (pom_wr) begin
        pom_buf <= wbyte;
      end
      if (xfer[LAST_STAGE]) begin
        pom_act <= pom_buf;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Per-stage registers and outputs
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_stage
      localparam bit IS_LAST = (gi == int'(LAST_STAGE));
      localparam logic [7:0] SOC_MASK = IS_LAST ? 8'hFF : SOC_MASK_PLAIN;
      localparam logic [7:0] CNF_MASK = IS_LAST ? 8'hFF : CNF_MASK_PLAIN;

      logic [7:0] soc_buf;
      logic [7:0] soc_act;
      logic [7:0] cnf;
      logic [11:0] sa_buf;
      logic [11:0] ra_buf;
      logic [11:0] sb_buf;
      logic [15:0] rb_buf;
      logic [11:0] sa_act;
      logic [11:0] ra_act;
      logic [11:0] sb_act;
      logic [15:0] rb_act;
      logic rb_last;
      scr_stage_out_s next_out;

      wire sel = wr_go & (dph_stage == 2'(gi));
      wire w_soc = sel & (dph_idx == R_SOC);
      wire w_cnf = sel & (dph_idx == R_CNF);
      wire w_sa = sel & (dph_idx == R_SAL);
      wire w_ra = sel & (dph_idx == R_RAL);
      wire w_sb = sel & (dph_idx == R_SBL);
      wire w_rb = sel & (dph_idx == R_RBL);
      wire w_pom = IS_LAST & pom_wr;
      wire [15:0] wr16 = {hi_latch, wbyte};
      wire half = cnf[CNF_HALF];
      wire alock = cnf[CNF_ALOCK];
      wire lock = cnf[CNF_LOCK];
      wire pol = cnf[CNF_POL];
      wire [3:0] m = {hit(st_in[gi].counter, rb_act[11:0]),
                      hit(st_in[gi].counter, sb_act),
                      hit(st_in[gi].counter, ra_act),
                      hit(st_in[gi].counter, sa_act)};
      wire end_cycle = m[3];
      wire other_wr = w_sa | w_ra | w_sb | w_soc | w_pom;
      wire use_matrix = IS_LAST & cnf[CNF_POME];
      wire pa = use_matrix ? pom_act[st_in[gi].ramp_idx]
                           : lvl(pol, st_in[gi].wave_a);
      wire pb = use_matrix ? pom_act[POM_B_LSB + st_in[gi].ramp_idx]
                           : lvl(pol, st_in[gi].wave_b);
      wire p2 = soc_act[SOC_OUT3_SOURCE_SEL] ? pb : pa;
      wire p3 = soc_act[SOC_OUT4_SOURCE_SEL] ? pa : pb;
      wire [3:0] oe = {soc_act[SOC_OEN_D] & IS_LAST,
                       soc_act[SOC_OEN_C] & IS_LAST,
                       soc_act[SOC_OEN_B],
                       soc_act[SOC_OEN_A]};

      // Auto-lock waits for reset-B at end of cycle; manual hold waits
      // for release; with neither set the buffer flows straight through.
      assign xfer[gi] = alock ? (end_cycle & rb_last) : ~lock;

      assign next_out.pin_val = {p3 & oe[3], p2 & oe[2],
                                 pb & oe[1], pa & oe[0]};
      assign next_out.pin_oe = oe;
      assign next_out.match = m;
      assign next_out.adc_sync = sync_pick(
        scr_run_mode_e'(cnf[CNF_MODE_HI:CNF_MODE_LO]),
        soc_act[SOC_SYNC_HI:SOC_SYNC_LO], m,
        st_in[gi].fault_a, st_in[gi].fault_b, st_in[gi].count_down);
      assign next_out.input_event_irq = st_in[gi].capture_evt |
                                        st_in[gi].sync_err;
      assign next_out.end_cycle_irq = end_cycle;
      assign next_out.clk_fast = cnf[CNF_CLK];
      assign next_out.half_duty = half;
      assign next_out.mode =
        scr_run_mode_e'(cnf[CNF_MODE_HI:CNF_MODE_LO]);

      // Pin level is driven only while enabled; otherwise the port
      // logic outside owns the pin.
      wire [2:0] stat = {rb_last, alock | lock, xfer[gi]};

      assign rd_word[gi] = rd_pick(dph_idx, IS_LAST, soc_buf, cnf, pom_buf,
                                   stat);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          soc_buf <= BYTE_RESET;
          cnf <= BYTE_RESET;
        end else begin
          if (w_soc) begin
            soc_buf <= wbyte & SOC_MASK;
          end
          if (w_cnf) begin
            cnf <= wbyte & CNF_MASK;
          end
        end
      end

      // ------------------------------------------------------------
      // Compare buffers
      // ------------------------------------------------------------
      // Buffered compare values; reset-B carries the flank fraction.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sa_buf <= CMP_RESET;
          ra_buf <= CMP_RESET;
          sb_buf <= CMP_RESET;
          rb_buf <= RB_RESET;
        end else begin
          if (w_sa) begin
            sa_buf <= wr16[11:0];
          end
          if (w_ra) begin
            ra_buf <= wr16[11:0];
          end
          if (w_sb) begin
            sb_buf <= wr16[11:0];
          end
          if (w_rb) begin
            rb_buf <= wr16;
          end
          if (w_rb && half) begin
            ra_buf <= wr16[11:0];
            sa_buf <= sb_buf;
          end
        end
      end

      // ------------------------------------------------------------
      // Transfer control
      // ------------------------------------------------------------
      // A new reset-B write wins over a clear in the same cycle.
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rb_last <= 1'b0;
        end else if (w_rb) begin
          rb_last <= 1'b1;
        end else if (other_wr || (alock && xfer[gi])) begin
          rb_last <= 1'b0;
        end
      end

      // ------------------------------------------------------------
      // Active copies and registered outputs
      // ------------------------------------------------------------
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          soc_act <= BYTE_RESET;
          sa_act <= CMP_RESET;
          ra_act <= CMP_RESET;
          sb_act <= CMP_RESET;
          rb_act <= RB_RESET;
        end else if (xfer[gi]) begin
          soc_act <= soc_buf;
          sa_act <= sa_buf;
          ra_act <= ra_buf;
          sb_act <= sb_buf;
          rb_act <= rb_buf;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_out[gi] <= '0;
        end else begin
          st_out[gi] <= next_out;
        end
      end
    end
  endgenerate

endmodule // scr_stage_ctrl_regs

// ==== verification/scr_stage_ctrl_regs_asserts.sv ====
// Assertions on the ports of the stage controller register block.
`timescale 1ns/1ps

module scr_stage_ctrl_regs_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire scr_pkg::scr_stage_in_s st_in [scr_pkg::STAGES],
  input wire scr_pkg::scr_stage_out_s st_out [scr_pkg::STAGES]
);
  import scr_pkg::*;
  logic wr_dp;
  logic [7:0] cfg_val;
  wire cfg_take = hsel && hready && htrans[1] && hwrite &&
    hsize == SIZE_WORD && haddr[7:2] == {2'h0, R_CNF};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      cfg_val <= BYTE_RESET;
    end else begin
      wr_dp <= cfg_take;
      if (wr_dp) cfg_val <= hwdata[7:0];
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_cfg_write;
    cfg_take ##1 hready;
  endsequence
  sequence s_cfg_seen;
    st_out[0].mode == scr_run_mode_e'(cfg_val[4:3]) &&
      st_out[0].clk_fast == cfg_val[CNF_CLK] &&
      st_out[0].half_duty == cfg_val[CNF_HALF];
  endsequence

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_rdata_byte: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_plain_oe: assert property (st_out[0].pin_oe[3:2] == 2'h0 &&
    st_out[1].pin_oe[3:2] == 2'h0)
    else $error("extra pins enabled on a plain stage");
  a_pin_quiet: assert property (
    (st_out[2].pin_val & ~st_out[2].pin_oe) == 4'h0)
    else $error("pin value driven while not enabled");
  a_input_event_irq_irq: assert property ($past(hresetn) |->
    st_out[2].input_event_irq ==
    $past(st_in[2].capture_evt || st_in[2].sync_err))
    else $error("input event request does not follow its causes");
  a_eoc_irq: assert property (
    st_out[0].end_cycle_irq == st_out[0].match[3])
    else $error("end of cycle request differs from reset-B match");
  a_cfg_apply: assert property (s_cfg_write |-> ##[1:3] s_cfg_seen)
    else $error("configuration not applied in time");
  a_dup_follow: assert property (st_out[2].pin_oe == 4'hF |->
    (st_out[2].pin_val[2] == st_out[2].pin_val[0] ||
    st_out[2].pin_val[2] == st_out[2].pin_val[1]) &&
    (st_out[2].pin_val[3] == st_out[2].pin_val[0] ||
    st_out[2].pin_val[3] == st_out[2].pin_val[1]))
    else $error("duplicated pin follows neither output");
endmodule  // scr_stage_ctrl_regs_asserts

bind scr_stage_ctrl_regs scr_stage_ctrl_regs_asserts u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .st_in(st_in), .st_out(st_out));

// ==== verification/scr_far_model.sv ====
// Generator and pin model on the far side of the stage block.
`timescale 1ns/1ps

module scr_far_model #(
  parameter logic [11:0] TOP = 12'h01F
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] ev,
  input wire scr_pkg::scr_stage_out_s st_out [scr_pkg::STAGES],
  output scr_pkg::scr_stage_in_s st_in [scr_pkg::STAGES],
  output logic [3:0] pin [scr_pkg::STAGES]
);
  import scr_pkg::*;
  logic [11:0] cnt;
  logic down;
  logic [1:0] ramp;
  logic [3:0] port;
  wire turn = cnt == TOP || (down && cnt != 12'h000);

  // The counter runs up and down so that center mode sees both directions.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 12'h000;
      down <= 1'b0;
      ramp <= 2'h0;
      port <= 4'h5;
    end else begin
      cnt <= turn ? cnt - 12'h001 : cnt + 12'h001;
      down <= cnt == TOP || (down && cnt != 12'h000);
      ramp <= ramp + 2'(cnt == 12'h000);
      port <= ~port;
    end
  end

  for (genvar s = 0; s < STAGES; s++) begin : g_st
    assign st_in[s] = '{counter: cnt ^ 12'(s), count_down: down,
      ramp_idx: ramp, wave_a: cnt < 12'h00C, wave_b: cnt[2],
      fault_a: ev[0], fault_b: ev[1], capture_evt: ev[2], sync_err: ev[3]};
    // A pin left to the port shows a pattern that changes every cycle.
    assign pin[s] = (st_out[s].pin_oe & st_out[s].pin_val) |
      (~st_out[s].pin_oe & port);
  end
endmodule  // scr_far_model

// ==== verification/tb_stage_ctrl_config_regs.sv ====
// Self-checking bench of the stage controller register block.
`timescale 1ns/1ps

module tb_stage_ctrl_config_regs;
  import scr_pkg::*;
  localparam logic [11:0] TOP = 12'h01F;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = SIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] ev = 4'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rng = 32'h0000_7BCB;
  scr_stage_in_s st_in [STAGES];
  scr_stage_out_s st_out [STAGES];
  logic [3:0] pin [STAGES];
  logic [7:0] soc [STAGES];
  logic [7:0] cnf [STAGES];
  logic [7:0] mtx = 8'h00;
  logic [15:0] bc [STAGES][4];
  logic [15:0] act [STAGES][4];
  logic [31:0] rd;
  int err_count = 0;
  int num_checks = 0;

  always #2 hclk = ~hclk;

  scr_stage_ctrl_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .st_in(st_in), .st_out(st_out));
  scr_far_model #(.TOP(TOP)) far (.hclk(hclk), .hresetn(hresetn),
    .ev(ev), .st_out(st_out), .st_in(st_in), .pin(pin));

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_rdy();
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (hreadyout !== 1'b1) begin
      chk(1'b0, "bus hang");
      wrap_up();
    end
  endtask

  task automatic xfer(bit w, int s, logic [3:0] i, logic [7:0] d,
    logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, 2'(s), i, 2'h0};
    hwrite <= w;
    hsize <= sz;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    #1;
    rd = hrdata;
    wait_rdy();
  endtask

  task automatic rdc(int s, logic [3:0] i, logic [7:0] e);
    xfer(1'b0, s, i, 8'h00, SIZE_WORD);
    chk(rd === {24'h000000, e}, "read value");
  endtask

  task automatic wcfg(int s, logic [7:0] sv, logic [7:0] cv);
    soc[s] = (s == 2) ? sv : (sv & SOC_MASK_PLAIN);
    cnf[s] = (s == 2) ? cv : (cv & CNF_MASK_PLAIN);
    xfer(1'b1, s, R_SOC, sv, SIZE_WORD);
    xfer(1'b1, s, R_CNF, cv, SIZE_WORD);
    rdc(s, R_SOC, soc[s]);
    rdc(s, R_CNF, cnf[s]);
  endtask

  task automatic wcmp(int s, int k, logic [15:0] v);
    xfer(1'b1, s, R_SAH + 4'(2 * k), v[15:8], SIZE_WORD);
    xfer(1'b1, s, R_SAL + 4'(2 * k), v[7:0], SIZE_WORD);
    bc[s][k] = (k == 3) ? v : {4'h0, v[11:0]};
    if (k == 3 && cnf[s][CNF_HALF]) begin
      bc[s][1] = {4'h0, v[11:0]};
      bc[s][0] = bc[s][2];
    end
    if (cnf[s][6:5] == 2'h0) act[s] = bc[s];
  endtask

  function automatic scr_stage_out_s model(int s, scr_stage_in_s p);
    scr_stage_out_s e;
    logic [3:0] m;
    logic [1:0] sel;
    logic a;
    logic b;
    for (int k = 0; k < 4; k++) m[k] = p.counter == act[s][k][11:0];
    a = p.wave_a ~^ cnf[s][CNF_POL];
    b = p.wave_b ~^ cnf[s][CNF_POL];
    if (s == 2 && cnf[s][CNF_POME]) begin
      a = mtx[p.ramp_idx];
      b = mtx[POM_B_LSB + p.ramp_idx];
    end
    sel = soc[s][5:4];
    e.pin_oe = {soc[s][3], soc[s][1], soc[s][2], soc[s][0]};
    e.pin_val = e.pin_oe & {soc[s][7] ? a : b, soc[s][6] ? b : a, b, a};
    e.match = m;
    if (cnf[s][4:3] == MODE_CENTER)
      e.adc_sync = m[1] && !sel[1] && p.count_down != sel[0];
    else
      e.adc_sync = sel[0] ? m[{sel[1], 1'b1}] ||
        (sel[1] ? p.fault_b : p.fault_a) : m[{sel[1], 1'b0}];
    e.input_event_irq = p.capture_evt || p.sync_err;
    e.end_cycle_irq = m[3];
    e.clk_fast = cnf[s][CNF_CLK];
    e.half_duty = cnf[s][CNF_HALF];
    e.mode = scr_run_mode_e'(cnf[s][4:3]);
    return e;
  endfunction

  task automatic run(int n);
    scr_stage_in_s p [STAGES];
    repeat (3) @(posedge hclk);
    repeat (n) begin
      @(posedge hclk);
      p = st_in;
      ev <= 4'(rnd());
      #1;
      for (int s = 0; s < STAGES; s++)
        chk(st_out[s] === model(s, p[s]), "stage outputs");
    end
  endtask

  initial begin
    for (int s = 0; s < STAGES; s++) begin
      soc[s] = 8'h00;
      cnf[s] = 8'h00;
      for (int k = 0; k < 4; k++) bc[s][k] = 16'h0000;
      act[s] = bc[s];
    end
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 64; a++)
      rdc(a / 16, 4'(a), (a % 16 == 11 && a < 48) ? 8'h01 : 8'h00);
    xfer(1'b1, 0, R_CNF, 8'hFF, 3'h0);
    rdc(0, R_CNF, 8'h00);
    run(20);
    $display("test reset_map done");
    for (int i = 0; i < 32; i++) begin
      int s;
      logic [7:0] sv;
      logic [7:0] cv;
      s = (i < 16) ? 2 : i % 3;
      sv = 8'(rnd());
      sv[5:4] = 2'(i >> 2);
      cv = 8'(rnd()) & 8'h9F;
      cv[4:3] = 2'(i);
      wcfg(s, sv, cv);
      mtx = 8'(rnd());
      xfer(1'b1, 2, R_POM, mtx, SIZE_WORD);
      for (int k = 0; k < 4; k++)
        wcmp(s, k, (16'(rnd()) & 16'hF01F) | 16'(k == 1));
      run(24);
    end
    $display("test random_config done");
    wcfg(0, soc[0], 8'h20);
    wcmp(0, 0, 16'h0005);
    run(70);
    wcfg(0, soc[0], 8'h00);
    act[0] = bc[0];
    run(70);
    $display("test manual_hold done");
    wcfg(2, soc[2], 8'h60);
    wcmp(2, 0, 16'h0007);
    run(70);
    wcfg(2, soc[2], 8'h40);
    run(70);
    wcmp(2, 3, 16'h0012);
    repeat (140) @(posedge hclk);
    act[2] = bc[2];
    run(40);
    $display("test auto_hold done");
    wrap_up();
  end
endmodule  // tb_stage_ctrl_config_regs
